// ---- src/sram_bw_decode.sv ----
// Write-enable, byte-lane and sleep decoder for a synchronous pipelined SRAM
//
// Summary of operation
// [R1] Write select high means a read cycle and every lane enable is ignored.
// [R2] Write select low with only lane 0 enabled writes data bits 1 to 8 and parity bit 0.
// [R3] Write select low with only lane 1 enabled writes data bits 9 to 16 and parity bit 1.
// [R4] On four lanes, only lane 2 enabled writes data bits 17 to 24 and parity bit 2.
// [R5] On four lanes, only lane 3 enabled writes data bits 25 to 32 and parity bit 3.
// [R6] All lanes enabled writes every lane; no lane enabled is an abort with no write.
// [R7] Sleep input low or open keeps the chip active, high puts it to sleep.
// [R8] A write needs at least one lane enable low; an abort leaves the data bus undriven.
// [R9] The controller holds write select or chip select high before raising sleep.
`timescale 1ns/100ps
module sram_bw_decode #(
	parameter int LANES = sram_bw_pkg::LANES_WIDE,
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Controller cycle inputs
	input wire logic chip_select_group_n,
	input wire logic write_select_n,
	input wire logic [LANES-1:0] lane_write_enable_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [LANES*sram_bw_pkg::LANE_BITS-1:0] data_in,
	input wire logic [LANES-1:0] lane_parity_in,
	input wire logic sleep_request,
	// Data bus drive
	output logic [LANES*sram_bw_pkg::LANE_BITS-1:0] data_out,
	output logic [LANES-1:0] lane_parity_out,
	output logic data_oe,
	// Decode status
	output logic [LANES-1:0] lane_written,
	output logic any_lane_write_enable_n,
	output logic write_abort,
	output logic read_cycle,
	output logic asleep
);
	// Lane width on the array: eight data bits and their parity bit
	localparam int LW = sram_bw_pkg::LANE_BITS + 1;
	// Pipeline: inputs land in the input registers at edge 0; the array is written and the status
	// outputs are registered at edge 1; read data and its bus enable follow at edge 2.
	// A read overtaken by sleep entry between edges 1 and 2 never drives the bus.

	logic sleep_meta_q;
	logic sleep_sync_q;
	logic cs_n_q;
	logic we_n_q;
	logic [LANES-1:0] bw_n_q;
	logic [ADDR_W-1:0] addr_q;
	logic [LANES*LW-1:0] wdata_q;
	logic [LANES-1:0] wr_lane;
	logic rd_en;
	logic [LANES*LW-1:0] rdata;
	logic rd_pend_q;
	logic [LANES*LW-1:0] wdata_pack;
	sram_bw_pkg::cycle_op_e cycle_op;

	// True when no lane enable is low
	function automatic logic no_lane(input logic [LANES-1:0] bw_n);
		no_lane = &bw_n;
	endfunction

	// Each lane carries its byte and its parity bit side by side
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_pack
			assign wdata_pack[g*LW +: LW] = {lane_parity_in[g], data_in[g*sram_bw_pkg::LANE_BITS +: sram_bw_pkg::LANE_BITS]};
		end
	endgenerate

	// Sleep pin is asynchronous; two flops before use
	always_ff @(posedge mclk) begin
		if (rst) begin
			sleep_meta_q <= 1'b0;
			sleep_sync_q <= 1'b0;
		end else begin
			sleep_meta_q <= sleep_request;
			sleep_sync_q <= sleep_meta_q;
		end
	end

	// Control inputs; they come from logic on the same clock
	// Reset leaves them deselected so no ghost cycle follows the release
	always_ff @(posedge mclk) begin
		if (rst) begin
			cs_n_q <= 1'b1;
			we_n_q <= 1'b1;
			bw_n_q <= '1;
		end else begin
			cs_n_q <= chip_select_group_n;
			we_n_q <= write_select_n;
			bw_n_q <= lane_write_enable_n;
		end
	end

	// Address and packed write data; only looked at when the control registers ask for it
	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_q <= '0;
			wdata_q <= '0;
		end else begin
			addr_q <= addr;
			wdata_q <= wdata_pack;
		end
	end

	// Cycle classification; deselect and sleep both make an idle cycle while state is kept
	always_comb begin
		if (cs_n_q || sleep_sync_q) begin
			cycle_op = sram_bw_pkg::OP_IDLE; // R7
		end else if (we_n_q) begin
			cycle_op = sram_bw_pkg::OP_READ; // R1
		end else if (no_lane(bw_n_q)) begin
			cycle_op = sram_bw_pkg::OP_ABORT; // R6 R8
		end else begin
			cycle_op = sram_bw_pkg::OP_WRITE; // R8
		end
	end

	// Lane strobes and read enable follow the classification; reads ignore the lane enables
	always_comb begin
		wr_lane = '0;
		rd_en = 1'b0;
		unique case (cycle_op)
			sram_bw_pkg::OP_READ: begin
				rd_en = 1'b1; // R1
			end
			sram_bw_pkg::OP_WRITE: begin
				wr_lane = ~bw_n_q; // R2 R3 R4 R5 R6
			end
			sram_bw_pkg::OP_IDLE, sram_bw_pkg::OP_ABORT: begin
				wr_lane = '0; // R6 R8
			end
		endcase
	end

	lane_mem #(
		.LANES(LANES),
		.LANE_W(LW),
		.ADDR_W(ADDR_W)
	) u_mem (
		.mclk(mclk),
		.wr_lane(wr_lane),
		.addr(addr_q),
		.wdata(wdata_q),
		.rd_en(rd_en),
		.rdata(rdata)
	);

	// Per-lane written pulse, one cycle behind the input registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			lane_written <= '0;
		end else begin
			lane_written <= wr_lane; // R2 R3 R4 R5
		end
	end

	// Any-lane flag tracks the registered enables every cycle, selected or not
	always_ff @(posedge mclk) begin
		if (rst) begin
			any_lane_write_enable_n <= 1'b1;
		end else begin
			any_lane_write_enable_n <= no_lane(bw_n_q); // R8
		end
	end

	// Abort pulse: a selected, awake write with every lane switched off
	always_ff @(posedge mclk) begin
		if (rst) begin
			write_abort <= 1'b0;
		end else begin
			write_abort <= (cycle_op == sram_bw_pkg::OP_ABORT); // R6
		end
	end

	// Read pulse, and the bus-drive request that the next stage turns into an enable
	always_ff @(posedge mclk) begin
		if (rst) begin
			read_cycle <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			read_cycle <= (cycle_op == sram_bw_pkg::OP_READ); // R1
			rd_pend_q <= rd_en;
		end
	end

	// Sleep status mirrors the synchronised pin, so it lines up with the cycle gating
	always_ff @(posedge mclk) begin
		if (rst) begin
			asleep <= 1'b0;
		end else begin
			asleep <= sleep_sync_q; // R7
		end
	end

	// Bus enable: only read data is driven; writes and aborts leave the bus undriven
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= rd_pend_q && !sleep_sync_q; // R8
		end
	end

	// Read data and parity unpacked from the array word; the array holds its word between reads
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_out <= '0;
			lane_parity_out <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				data_out[i*sram_bw_pkg::LANE_BITS +: sram_bw_pkg::LANE_BITS] <= rdata[i*LW +: sram_bw_pkg::LANE_BITS];
				lane_parity_out[i] <= rdata[i*LW+sram_bw_pkg::LANE_BITS];
			end
		end
	end
endmodule

// ---- src/sram_bw_pkg.sv ----
// Constants shared by the byte-write and sleep decoder
package sram_bw_pkg;
	localparam int LANE_BITS = 8;
	localparam int LANES_WIDE = 4;
	localparam int LANES_NARROW = 2;
	localparam logic [3:0] ALL_LANES_OFF_N = 4'hF;
	localparam logic [1:0] OP_RESET = 2'h0;
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE, OP_ABORT} cycle_op_e;
endpackage

// ---- src/lane_mem.sv ----
// Byte-lane memory with per-lane write enables and registered read data
`timescale 1ns/100ps
module lane_mem #(
	parameter int LANES = 4,
	parameter int LANE_W = 9,
	parameter int ADDR_W = 6
) (
	// Clock
	input wire logic mclk,
	// Write side
	input wire logic [LANES-1:0] wr_lane,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [LANES*LANE_W-1:0] wdata,
	// Read side
	input wire logic rd_en,
	output logic [LANES*LANE_W-1:0] rdata
);
	logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Each lane is written on its own; others keep their contents
	// One process owns the whole array, since a dynamic index forbids splitting it across processes
	always_ff @(posedge mclk) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_lane[i]) begin
				mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
			end
		end
	end

	// Read data registered, no reset on the array
	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end
endmodule

// ---- bench/sram_bw_decode_properties.sv ----
// Port checks for the byte-write and sleep decoder
`timescale 1ns/100ps
module sram_bw_decode_properties #(parameter int LANES = 4) (
	// Watched ports
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_select_group_n,
	input wire logic write_select_n,
	input wire logic [LANES-1:0] lane_write_enable_n,
	input wire logic sleep_request,
	input wire logic [LANES-1:0] lane_written,
	input wire logic any_lane_write_enable_n,
	input wire logic write_abort,
	input wire logic read_cycle,
	input wire logic data_oe,
	input wire logic asleep
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A request is acted on when selected; asleep seen two edges on shows whether sleep gated it
	wire logic sel = !chip_select_group_n;
	wire logic wr = sel && !write_select_n;
	wire logic [LANES-1:0] en_n = lane_write_enable_n;
	a_read_ignores_lanes: assert property (sel && write_select_n ##2 !asleep |-> read_cycle && lane_written == '0)
		else $error("read not decoded");
	a_lane_decode: assert property (wr ##2 !asleep |-> lane_written == ~$past(en_n, 2))
		else $error("wrong lanes written");
	a_abort_decode: assert property (wr && &en_n ##2 !asleep |-> write_abort)
		else $error("abort missed");
	a_any_lane_flag: assert property (wr |-> ##2 any_lane_write_enable_n == &$past(en_n, 2))
		else $error("any-lane flag wrong");
	a_sleep_blocks: assert property (asleep |-> lane_written == '0 && !read_cycle && !write_abort)
		else $error("cycle acted while asleep");
	a_read_drives_bus: assert property (read_cycle ##1 !asleep |-> data_oe)
		else $error("read data not driven");
	a_bus_only_reads: assert property (data_oe |-> $past(read_cycle))
		else $error("bus driven without a read");
	a_abort_bus_idle: assert property (write_abort |=> !data_oe)
		else $error("bus driven on abort");
	a_deselect_idle: assert property (chip_select_group_n |-> ##2 !read_cycle && !write_abort && lane_written == '0)
		else $error("deselected cycle acted");
	a_sleep_entry: assert property (sleep_request [*3] |=> asleep)
		else $error("sleep not entered");
	a_sleep_exit: assert property (!sleep_request [*3] |=> !asleep)
		else $error("sleep not left");
	c_read: cover property (read_cycle);
	c_abort: cover property (write_abort);
	c_sleep: cover property (asleep);
	c_all_lanes: cover property (&lane_written);
endmodule

// ---- bench/ctrl_model.sv ----
// Memory controller model driving the decoder's cycle inputs
`timescale 1ns/100ps
module ctrl_model (
	// Clock
	input wire logic mclk,
	// Cycle request
	output logic cs_n,
	output logic we_n,
	output logic [3:0] lane_n,
	output logic [5:0] addr,
	output logic [31:0] data,
	output logic [3:0] par,
	output logic sleep
);
	// Deselected at time zero
	initial {cs_n, we_n, lane_n, addr, data, par, sleep} = {6'h3F, 42'h0, 1'h0};
	// One request per clock, changed on the falling edge
	task automatic cyc(input logic [5:0] c, input logic [41:0] v);
		@(negedge mclk);
		{cs_n, we_n, lane_n} = c;
		{addr, data, par} = v;
	endtask
	// Sleep moves on the same falling edge that deselects, so no write is pending when it takes effect
	task automatic doze(input logic s);
		cyc(6'h3F, ~{addr, data, par});
		sleep = s;
	endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the byte-write and sleep decoder
`timescale 1ns/100ps
module tb;
	logic mclk = 0, rst = 1, cs_n, we_n, sleep, oe, anyn, ab, rd, slp;
	logic [3:0] lane_n, par, par_o, lw;
	logic [5:0] addr;
	logic [31:0] data, dout;
	logic [35:0] m = 36'h0;
	int num_errors = 0, samples_checked = 0;
	sram_bw_decode i_dut (.mclk, .rst, .chip_select_group_n(cs_n), .write_select_n(we_n), .lane_write_enable_n(lane_n),
		.addr, .data_in(data), .lane_parity_in(par), .sleep_request(sleep), .data_out(dout), .lane_parity_out(par_o),
		.data_oe(oe), .lane_written(lw), .any_lane_write_enable_n(anyn), .write_abort(ab), .read_cycle(rd), .asleep(slp));
	ctrl_model i_ctrl (.mclk, .cs_n, .we_n, .lane_n, .addr, .data, .par, .sleep);
	initial forever #2 mclk = ~mclk;
	// Compare one result
	task automatic chk(input logic [35:0] g, e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One request, status while its one-cycle pulses stand, then bus enable and read data a cycle later
	task automatic op(input logic [5:0] c, input logic [35:0] w, input logic [5:0] es);
		i_ctrl.cyc(c, {6'h5, w[31:0], w[35:32]});
		i_ctrl.cyc(6'h3F, ~{6'h5, w[31:0], w[35:32]});
		@(negedge mclk);
		chk(36'({lw, ab, rd, anyn}), 36'({es, &c[3:0]}));
		@(negedge mclk);
		chk(36'(oe), 36'(es[0]));
		if (es[0]) chk({par_o, dout}, m);
	endtask
	// All-lanes, single-lane and no-lane codes, each read back with all lane enables low
	task automatic t_lanes();
		logic [3:0] codes [6] = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
		logic [35:0] w;
		for (int k = 0; k < 6; k++) begin
			w = 36'h512345678 + 36'(k) * 36'h111111111;
			for (int i = 0; i < 4; i++) if (!codes[k][i]) {m[32 + i], m[8 * i +: 8]} = {w[32 + i], w[8 * i +: 8]};
			op({2'b00, codes[k]}, w, {~codes[k], codes[k] == 4'hF, 1'b0});
			op(6'h10, ~w, 6'h1);
		end
	endtask
	// Deselected write, refused write while asleep, then wake and read
	task automatic t_sleep();
		op(6'h20, 36'h0, 6'h0);
		i_ctrl.doze(1'b1);
		repeat (4) @(negedge mclk);
		chk(36'(slp), 36'h1);
		op(6'h00, 36'h0, 6'h0);
		i_ctrl.doze(1'b0);
		repeat (4) @(negedge mclk);
		chk(36'(slp), 36'h0);
		op(6'h10, 36'h0, 6'h1);
	endtask
	// Verdict
	task automatic finish_test();
		if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Reset, scenarios, close
	initial begin
		repeat (4) @(negedge mclk);
		rst = 0;
		chk(36'({lw, ab, rd, anyn}), 36'h1);
		t_lanes();
		t_sleep();
		finish_test();
	end
	// Hang guard, well past the expected run
	initial begin
		#4000;
		num_errors++;
		finish_test();
	end
endmodule
bind sram_bw_decode sram_bw_decode_properties #(.LANES(LANES)) i_props (.mclk(mclk), .rst(rst),
	.chip_select_group_n(chip_select_group_n), .write_select_n(write_select_n),
	.lane_write_enable_n(lane_write_enable_n), .sleep_request(sleep_request), .lane_written(lane_written),
	.any_lane_write_enable_n(any_lane_write_enable_n), .write_abort(write_abort), .read_cycle(read_cycle),
	.data_oe(data_oe), .asleep(asleep));
